// [include/ppa_pkg.sv]
// Functional notes
// - A digital pad left undriven gets its weak pull-up toward the I/O supply.
// - The weak pull-up is off on any pad that is driving low.
// - Global pull-up disable set to 1 turns off every weak pull-up.
// - Port data reads return the synchronised pad level, never the output latch.
// - Ports zero to three take analog or digital; the port four pin is digital only.
// - A pin with its skip bit at 1 is withheld from the crossbar.
// - Reference on P0.0, crystal on P0.2, oscillator on P0.3; ADC ports 0-3, comparators 0-2.
// - Each comparator has separate four-bit positive and negative selects in its register.
// - Both comparator selects may name the same pin at once without conflict.
// - With supply reference and ADC enabled, P0.0 cannot drive as open-drain.
// - ADC temperature channel results are invalid while the sensor enable is clear.
// - Each skip bit controls its pin: 0 available to crossbar, 1 passed over.
package ppa_pkg;
  localparam int NPORT = 5;
  localparam int NPIN = 33;
  localparam int AW = 8;
  localparam int SEL_W = 4;
  localparam int CMP_PINS = 24;
  localparam int ADC_PINS = 32;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMP0_OFS = 8'h04;
  localparam logic [7:0] CMP1_OFS = 8'h08;
  localparam logic [7:0] ADCMX_OFS = 8'h0C;
  localparam logic [7:0] SKIP_BASE = 8'h10;
  localparam logic [7:0] DATA_BASE = 8'h24;
  localparam logic [7:0] DIG_BASE = 8'h38;
  localparam logic [7:0] PP_BASE = 8'h4C;
  localparam logic [7:0] BANK_SPAN = 8'h14;
  // ==========================================================
  // Fields
  localparam int CTRL_GPD = 0;
  localparam int CTRL_VREF_SUPPLY = 1;
  localparam int CTRL_TEMP_SENSOR_ENABLE = 2;
  localparam int CTRL_ADCEN = 3;
  localparam int CMP_NEG_LSB = 0;
  localparam int CMP_POS_LSB = 4;
  localparam int ADC_FIELD_W = 5;
  localparam int ADC_TEMP_BIT = 5;
  localparam int REF_PIN = 0;
  localparam int CRYSTAL_INPUT_PIN_PIN = 2;
  localparam int OSCILLATOR_SECOND_PIN_PIN = 3;
  localparam logic [2:0] PORT4_IDX = 3'h4;
  localparam logic [7:0] PORT4_MASK = 8'h01;
  localparam logic [7:0] FULL_MASK = 8'hFF;
  localparam logic [NPIN-1:0] PIN4_FORCE_DIG = 33'h1_0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Types
  typedef struct packed {
    logic [3:0] ctrl;
    logic [7:0] cmp0;
    logic [7:0] cmp1;
    logic [5:0] adcmx;
    logic [NPORT-1:0][7:0] skip;
    logic [NPORT-1:0][7:0] latch;
    logic [NPORT-1:0][7:0] digital;
    logic [NPORT-1:0][7:0] pp;
  } ppa_regs_s;
  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe_n;
    logic [NPIN-1:0] pullup_en;
    logic [NPIN-1:0] analog;
  } ppa_pad_s;
  typedef struct packed {
    logic vref_conn;
    logic crystal_input_pin_conn;
    logic oscillator_second_pin_conn;
    logic adc_temp_sel;
    logic temp_data_valid;
    logic [CMP_PINS-1:0] cmp_pin_ok;
    logic [ADC_PINS-1:0] adc_pin_ok;
  } ppa_ana_s;
  localparam ppa_regs_s REGS_RST = '{ctrl: 4'h0, cmp0: 8'h00, cmp1: 8'h00, adcmx: 6'h00,
    skip: {NPORT{8'h00}}, latch: {NPORT{8'hFF}}, digital: {NPORT{8'hFF}}, pp: {NPORT{8'h00}}};
endpackage

// [core/ppa_top.sv]
`timescale 1ns/1ps
`default_nettype none
module ppa_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ppa_pkg::AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ppa_pkg::AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Pads
  input wire logic [ppa_pkg::NPIN-1:0] pad_in,
  output ppa_pkg::ppa_pad_s pad,
  // Crossbar and analog side
  output logic [ppa_pkg::NPIN-1:0] xbar_skip,
  output ppa_pkg::ppa_ana_s ana,
  output logic [ppa_pkg::SEL_W-1:0] cmp0_positive_select,
  output logic [ppa_pkg::SEL_W-1:0] cmp0_negative_select,
  output logic [ppa_pkg::SEL_W-1:0] cmp1_positive_select,
  output logic [ppa_pkg::SEL_W-1:0] cmp1_negative_select,
  output logic [ppa_pkg::ADC_FIELD_W-1:0] adc_channel_field,
  output logic temp_sensor_enable,
  output logic ref_supply_sel,
  output logic adc_enable
);
  // ==========================================================
  // Helpers
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + ppa_pkg::BANK_SPAN) && (a[1:0] == 2'h0);
  endfunction
  function automatic logic [2:0] bank_idx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] off;
    off = a - base;
    return off[4:2];
  endfunction
  function automatic logic [7:0] port_mask(input logic [2:0] idx);
    return (idx == ppa_pkg::PORT4_IDX) ? ppa_pkg::PORT4_MASK : ppa_pkg::FULL_MASK;
  endfunction

  // ==========================================================
  // State
  ppa_pkg::ppa_regs_s regs_q, regs_d;
  ppa_pkg::ppa_pad_s pad_q, pad_d;
  ppa_pkg::ppa_ana_s ana_q, ana_d;
  logic [ppa_pkg::NPIN-1:0] meta_q, meta_d, sync_q, sync_d, skip_out_q, skip_out_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  // ==========================================================
  // Flattened per-pin views
  logic [8*ppa_pkg::NPORT-1:0] skip_f, latch_f, dig_f, pp_f, pad_f;
  logic [ppa_pkg::NPIN-1:0] dig_v, drive_v, lock_v;
  logic wr_fire, lock0;
  assign skip_f = regs_q.skip;
  assign latch_f = regs_q.latch;
  assign dig_f = regs_q.digital;
  assign pp_f = regs_q.pp;
  assign pad_f = {7'h00, sync_q};
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  // Port four pin has no analog path, so it is always digital
  assign dig_v = dig_f[ppa_pkg::NPIN-1:0] | ppa_pkg::PIN4_FORCE_DIG;
  // Supply reference with ADC on: no open-drain drive on the reference pin
  assign lock0 = regs_q.ctrl[ppa_pkg::CTRL_VREF_SUPPLY] && regs_q.ctrl[ppa_pkg::CTRL_ADCEN]
    && !pp_f[ppa_pkg::REF_PIN];
  assign lock_v = {{(ppa_pkg::NPIN-1){1'b0}}, lock0};
  // Open-drain drives low only; push-pull drives both levels
  assign drive_v = dig_v & ~lock_v & (pp_f[ppa_pkg::NPIN-1:0] | ~latch_f[ppa_pkg::NPIN-1:0]);

  // ==========================================================
  // Pad and analog next values
  always_comb begin
    meta_d = pad_in;
    sync_d = meta_q;
    skip_out_d = skip_f[ppa_pkg::NPIN-1:0];
    pad_d.out = latch_f[ppa_pkg::NPIN-1:0];
    pad_d.oe_n = ~drive_v;
    pad_d.analog = ~dig_v;
    // Pull-up only on digital pads not pulling low, and never when globally off
    pad_d.pullup_en = {ppa_pkg::NPIN{~regs_q.ctrl[ppa_pkg::CTRL_GPD]}} & dig_v
      & ~(drive_v & ~latch_f[ppa_pkg::NPIN-1:0]);
    ana_d.vref_conn = ~dig_v[ppa_pkg::REF_PIN] & skip_f[ppa_pkg::REF_PIN];
    ana_d.crystal_input_pin_conn = ~dig_v[ppa_pkg::CRYSTAL_INPUT_PIN_PIN] & skip_f[ppa_pkg::CRYSTAL_INPUT_PIN_PIN];
    ana_d.oscillator_second_pin_conn = ~dig_v[ppa_pkg::OSCILLATOR_SECOND_PIN_PIN] & skip_f[ppa_pkg::OSCILLATOR_SECOND_PIN_PIN];
    ana_d.cmp_pin_ok = ~dig_v[ppa_pkg::CMP_PINS-1:0] & skip_f[ppa_pkg::CMP_PINS-1:0];
    ana_d.adc_pin_ok = ~dig_v[ppa_pkg::ADC_PINS-1:0] & skip_f[ppa_pkg::ADC_PINS-1:0];
    ana_d.adc_temp_sel = regs_q.adcmx[ppa_pkg::ADC_TEMP_BIT];
    ana_d.temp_data_valid = regs_q.adcmx[ppa_pkg::ADC_TEMP_BIT]
      & regs_q.ctrl[ppa_pkg::CTRL_TEMP_SENSOR_ENABLE];
  end

  // ==========================================================
  // Bus next values
  always_comb begin
    logic [2:0] widx;
    logic [2:0] ridx;
    widx = 3'h0;
    ridx = 3'h0;
    regs_d = regs_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = ppa_pkg::RESP_OKAY;
      if (awaddr_q == ppa_pkg::CTRL_OFS) begin
        if (wstrb_q[0]) regs_d.ctrl = wdata_q[3:0];
      end else if (awaddr_q == ppa_pkg::CMP0_OFS) begin
        if (wstrb_q[0]) regs_d.cmp0 = wdata_q[7:0];
      end else if (awaddr_q == ppa_pkg::CMP1_OFS) begin
        if (wstrb_q[0]) regs_d.cmp1 = wdata_q[7:0];
      end else if (awaddr_q == ppa_pkg::ADCMX_OFS) begin
        if (wstrb_q[0]) regs_d.adcmx = wdata_q[5:0];
      end else if (in_bank(awaddr_q, ppa_pkg::SKIP_BASE)) begin
        widx = bank_idx(awaddr_q, ppa_pkg::SKIP_BASE);
        if (wstrb_q[0]) regs_d.skip[widx] = wdata_q[7:0] & port_mask(widx);
      end else if (in_bank(awaddr_q, ppa_pkg::DATA_BASE)) begin
        widx = bank_idx(awaddr_q, ppa_pkg::DATA_BASE);
        if (wstrb_q[0]) regs_d.latch[widx] = wdata_q[7:0] & port_mask(widx);
      end else if (in_bank(awaddr_q, ppa_pkg::DIG_BASE)) begin
        widx = bank_idx(awaddr_q, ppa_pkg::DIG_BASE);
        if (wstrb_q[0]) regs_d.digital[widx] = wdata_q[7:0] & port_mask(widx);
      end else if (in_bank(awaddr_q, ppa_pkg::PP_BASE)) begin
        widx = bank_idx(awaddr_q, ppa_pkg::PP_BASE);
        if (wstrb_q[0]) regs_d.pp[widx] = wdata_q[7:0] & port_mask(widx);
      end else begin
        bresp_d = ppa_pkg::RESP_SLVERR;
      end
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = ppa_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (araddr == ppa_pkg::CTRL_OFS) begin
        rdata_d[3:0] = regs_q.ctrl;
      end else if (araddr == ppa_pkg::CMP0_OFS) begin
        rdata_d[7:0] = regs_q.cmp0;
      end else if (araddr == ppa_pkg::CMP1_OFS) begin
        rdata_d[7:0] = regs_q.cmp1;
      end else if (araddr == ppa_pkg::ADCMX_OFS) begin
        rdata_d[5:0] = regs_q.adcmx;
      end else if (in_bank(araddr, ppa_pkg::SKIP_BASE)) begin
        ridx = bank_idx(araddr, ppa_pkg::SKIP_BASE);
        rdata_d[7:0] = regs_q.skip[ridx];
      end else if (in_bank(araddr, ppa_pkg::DATA_BASE)) begin
        ridx = bank_idx(araddr, ppa_pkg::DATA_BASE);
        rdata_d[7:0] = pad_f[{ridx, 3'h0} +: 8];
      end else if (in_bank(araddr, ppa_pkg::DIG_BASE)) begin
        ridx = bank_idx(araddr, ppa_pkg::DIG_BASE);
        rdata_d[7:0] = (ridx == ppa_pkg::PORT4_IDX) ? ppa_pkg::PORT4_MASK : regs_q.digital[ridx];
      end else if (in_bank(araddr, ppa_pkg::PP_BASE)) begin
        ridx = bank_idx(araddr, ppa_pkg::PP_BASE);
        rdata_d[7:0] = regs_q.pp[ridx];
      end else begin
        rresp_d = ppa_pkg::RESP_SLVERR;
      end
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs_q <= ppa_pkg::REGS_RST;
      // Pads float on their pull-ups in reset rather than being driven low
      pad_q <= '{out: '1, oe_n: '1, pullup_en: '1, analog: '0};
      ana_q <= '0;
      meta_q <= '0;
      sync_q <= '0;
      skip_out_q <= '0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      regs_q <= regs_d;
      pad_q <= pad_d;
      ana_q <= ana_d;
      meta_q <= meta_d;
      sync_q <= sync_d;
      skip_out_q <= skip_out_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign pad = pad_q;
  assign ana = ana_q;
  assign xbar_skip = skip_out_q;
  // Selects come straight from the registers; no arbitration, both may share a pin
  assign cmp0_positive_select = regs_q.cmp0[ppa_pkg::CMP_POS_LSB +: ppa_pkg::SEL_W];
  assign cmp0_negative_select = regs_q.cmp0[ppa_pkg::CMP_NEG_LSB +: ppa_pkg::SEL_W];
  assign cmp1_positive_select = regs_q.cmp1[ppa_pkg::CMP_POS_LSB +: ppa_pkg::SEL_W];
  assign cmp1_negative_select = regs_q.cmp1[ppa_pkg::CMP_NEG_LSB +: ppa_pkg::SEL_W];
  assign adc_channel_field = regs_q.adcmx[ppa_pkg::ADC_FIELD_W-1:0];
  assign temp_sensor_enable = regs_q.ctrl[ppa_pkg::CTRL_TEMP_SENSOR_ENABLE];
  assign ref_supply_sel = regs_q.ctrl[ppa_pkg::CTRL_VREF_SUPPLY];
  assign adc_enable = regs_q.ctrl[ppa_pkg::CTRL_ADCEN];

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] rd_pad_byte;
  assign rd_pad_byte = pad_f[{bank_idx(araddr, ppa_pkg::DATA_BASE), 3'h0} +: 8];

  a_pullup_hiz_on: assert property (((~pad.analog & pad.oe_n & ~pad.pullup_en) != '0)
    |-> $past(regs_q.ctrl[ppa_pkg::CTRL_GPD])) else $error("Undriven digital pad lacks pull-up");
  a_pullup_low_off: assert property ((~pad.oe_n & ~pad.out & pad.pullup_en) == '0)
    else $error("Pull-up on while driving low");
  a_global_pu_off: assert property ($past(regs_q.ctrl[ppa_pkg::CTRL_GPD]) |-> pad.pullup_en == '0)
    else $error("Pull-up on under global disable");
  a_read_pad_level: assert property ((arvalid && arready && in_bank(araddr, ppa_pkg::DATA_BASE))
    |=> rvalid && rdata[7:0] == $past(rd_pad_byte)) else $error("Port read not pad level");
  a_port4_digital: assert property (!pad.analog[ppa_pkg::NPIN-1])
    else $error("Port four pin in analog mode");
  a_skip_write_out: assert property ((wr_fire && awaddr_q == ppa_pkg::SKIP_BASE && wstrb_q[0])
    |-> ##2 xbar_skip[7:0] == $past(wdata_q[7:0], 2)) else $error("Skip write not applied");
  a_vref_conn_ok: assert property (ana.vref_conn |-> pad.analog[ppa_pkg::REF_PIN]
    && xbar_skip[ppa_pkg::REF_PIN]) else $error("Reference pin not reserved");
  a_cmp_sel_load: assert property ((wr_fire && awaddr_q == ppa_pkg::CMP0_OFS && wstrb_q[0])
    |=> {cmp0_positive_select, cmp0_negative_select} == $past(wdata_q[7:0]))
    else $error("Comparator select not loaded");
  a_cmp_independent: assert property ((wr_fire && awaddr_q == ppa_pkg::CMP1_OFS)
    |=> $stable(cmp0_positive_select) && $stable(cmp0_negative_select))
    else $error("Comparator selects interfere");
  a_vref_no_od: assert property ($past(lock0) |-> pad.oe_n[ppa_pkg::REF_PIN])
    else $error("Reference pin driven open-drain");
  a_temp_valid_en: assert property (ana.temp_data_valid |-> $past(temp_sensor_enable))
    else $error("Temperature data valid with sensor off");
  a_skip_reset_zero: assert property (@(posedge aclk) disable iff (1'b0)
    $past(!aresetn) |-> regs_q.skip == '0) else $error("Skip masks not zero after reset");
endmodule
`default_nettype wire

// [tb/ppa_pads.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Pad wiring: block drive, outside driver, pull-up, float
module ppa_pads (
  // Pad control from the block
  input wire ppa_pkg::ppa_pad_s pad,
  // Outside drivers
  input wire logic [ppa_pkg::NPIN-1:0] ext_en,
  input wire logic [ppa_pkg::NPIN-1:0] ext_val,
  // Levels seen at the pads
  output logic [ppa_pkg::NPIN-1:0] pad_in
);
  // Floating pad without pull-up shows the inverse of the latch, so a stale level never reads as valid
  always_comb begin
    for (int i = 0; i < ppa_pkg::NPIN; i++) begin
      if (!pad.oe_n[i]) begin
        pad_in[i] = pad.out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad.pullup_en[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ~pad.out[i];
      end
    end
  end
endmodule
`default_nettype wire

// [tb/test_port_analog_pin_assignment.sv]
`timescale 1ns/1ps
`default_nettype none
module test_port_analog_pin_assignment;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tse, rss, aen;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, c0p, c0n, c1p, c1n;
  logic [1:0] bresp, rresp, r;
  logic [4:0] adc_f;
  logic [32:0] pad_in, xbar_skip, ext_en, ext_val;
  ppa_pkg::ppa_pad_s pad;
  ppa_pkg::ppa_ana_s ana;
  int n_errors, compares;

  ppa_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pad_in(pad_in), .pad(pad), .xbar_skip(xbar_skip), .ana(ana),
    .cmp0_positive_select(c0p), .cmp0_negative_select(c0n), .cmp1_positive_select(c1p),
    .cmp1_negative_select(c1n), .adc_channel_field(adc_f), .temp_sensor_enable(tse),
    .ref_supply_sel(rss), .adc_enable(aen));
  ppa_pads pads_u (.pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ==========================================================
  // Bus tasks and compare
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ends two edges after the response so pad outputs have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    close_out();
  end

  // ==========================================================
  // Tests
  initial begin
    n_errors = 0;
    compares = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    ext_en = '0;
    ext_val = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("oe_n reset", pad.oe_n, '1);
    chk("pullup reset", pad.pullup_en, '1);
    chk("skip out reset", xbar_skip, '0);
    for (int p = 0; p < 5; p++) begin
      rd(ppa_pkg::SKIP_BASE + 8'(4 * p));
      chk("skip reg reset", 33'(d), '0);
      rd(ppa_pkg::DATA_BASE + 8'(4 * p));
      chk("pulled up level", 33'(d), (p == 4) ? 33'h1 : 33'hFF);
    end
    for (int p = 0; p < 5; p++) begin
      wr(ppa_pkg::SKIP_BASE + 8'(4 * p), 32'(8'hA5 ^ 8'(p)));
      rd(ppa_pkg::SKIP_BASE + 8'(4 * p));
      chk("skip reg", 33'(d), (p == 4) ? 33'h1 : 33'(8'hA5 ^ 8'(p)));
    end
    chk("skip pins", xbar_skip, 33'h1_A6A7_A4A5);
    // Port one: upper nibble driven low, lower nibble open-drain high
    wr(ppa_pkg::DATA_BASE + 8'h04, 32'h0F);
    chk("oe_n port1", 33'(pad.oe_n[15:8]), 33'h0F);
    chk("pullup port1", 33'(pad.pullup_en[15:8]), 33'h0F);
    repeat (4) @(posedge aclk);
    rd(ppa_pkg::DATA_BASE + 8'h04);
    chk("pad read port1", 33'(d), 33'h0F);
    ext_en[8] <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(ppa_pkg::DATA_BASE + 8'h04);
    chk("pad pulled low", 33'(d), 33'h0E);
    wr(ppa_pkg::CTRL_OFS, 32'h1);
    chk("pullup disabled", pad.pullup_en, '0);
    rd(ppa_pkg::CTRL_OFS);
    chk("ctrl read", 33'(d), 33'h1);
    wr(ppa_pkg::CTRL_OFS, 32'h0);
    ext_en[8] <= 1'b0;
    chk("pullup back", 33'(pad.pullup_en[15:8]), 33'h0F);
    // Reference pin with supply reference and converter on
    wr(ppa_pkg::DATA_BASE, 32'hFE);
    chk("p00 od low", 33'(pad.oe_n[0]), 33'h0);
    wr(ppa_pkg::CTRL_OFS, 32'hA);
    chk("ref and adc", 33'({rss, aen}), 33'h3);
    chk("p00 od blocked", 33'(pad.oe_n[0]), 33'h1);
    wr(ppa_pkg::PP_BASE, 32'h1);
    chk("p00 push-pull", 33'({pad.oe_n[0], pad.out[0]}), 33'h0);
    wr(ppa_pkg::PP_BASE, 32'h0);
    wr(ppa_pkg::CTRL_OFS, 32'h0);
    // Analog pins: software sets mode and skip
    wr(ppa_pkg::DIG_BASE, 32'hF2);
    wr(ppa_pkg::SKIP_BASE, 32'h0D);
    chk("analog port0", 33'(pad.analog[7:0]), 33'h0D);
    chk("ref xtal conn", 33'({ana.vref_conn, ana.crystal_input_pin_conn, ana.oscillator_second_pin_conn}), 33'h7);
    chk("cmp pins ok", 33'(ana.cmp_pin_ok), 33'h0D);
    wr(ppa_pkg::SKIP_BASE, 32'h05);
    chk("oscillator_second_pin unskipped", 33'({ana.vref_conn, ana.crystal_input_pin_conn, ana.oscillator_second_pin_conn}), 33'h6);
    chk("adc pins ok", 33'(ana.adc_pin_ok), 33'h05);
    wr(ppa_pkg::DIG_BASE + 8'h10, 32'h0);
    rd(ppa_pkg::DIG_BASE + 8'h10);
    chk("port4 digital", 33'(d), 33'h1);
    chk("port4 not analog", 33'(pad.analog[32]), 33'h0);
    // Comparator selects, both comparators on the same two pins
    wr(ppa_pkg::CMP0_OFS, 32'h5A);
    wr(ppa_pkg::CMP1_OFS, 32'h5A);
    chk("cmp shared", 33'({c0p, c0n, c1p, c1n}), 33'h5A5A);
    wr(ppa_pkg::CMP1_OFS, 32'h3C);
    chk("cmp separate", 33'({c0p, c0n, c1p, c1n}), 33'h5A3C);
    rd(ppa_pkg::CMP0_OFS);
    chk("cmp0 read", 33'(d), 33'h5A);
    // Low byte strobe off: answered, nothing written
    wstrb <= 4'h0;
    wr(ppa_pkg::CMP0_OFS, 32'hFF);
    wstrb <= 4'hF;
    chk("cmp0 no strobe", 33'({c0p, c0n}), 33'h5A);
    chk("no strobe resp", 33'(r), 33'(ppa_pkg::RESP_OKAY));
    // Temperature channel
    wr(ppa_pkg::ADCMX_OFS, 32'h3F);
    chk("adc sel", 33'({adc_f, ana.adc_temp_sel, ana.temp_data_valid}), 33'h7E);
    wr(ppa_pkg::CTRL_OFS, 32'h4);
    chk("temp valid", 33'({tse, ana.temp_data_valid}), 33'h3);
    // Unmapped place
    wr(8'hF0, 32'hFF);
    chk("unmapped write", 33'(r), 33'(ppa_pkg::RESP_SLVERR));
    rd(8'hF0);
    chk("unmapped read", 33'(r), 33'(ppa_pkg::RESP_SLVERR));
    // Second reset in mid-run: masks set above must clear again
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("skip out rereset", xbar_skip, '0);
    chk("oe_n rereset", pad.oe_n, '1);
    rd(ppa_pkg::SKIP_BASE);
    chk("skip reg rereset", 33'(d), '0);
    close_out();
  end
endmodule
`default_nettype wire
